// ===== cpu_register_file_and_status.sv
// Function
// - 32 general, up to 18 special, 32-bit
// - General registers zero only at configuration load
// - No reset input touches general registers
// - Zero register reads zero, writes dropped
// - Interrupt stores return address in its link
// - Break stores return address in its link
// - Exception link, or branch target in delay slot
// - Program counter readable at selector zero only
// - Reads give own address; resets to zero
// - Status read copies carry into bit 0
// - Status written by move, set, clear
// - Set/clear: carry now, others one cycle later
// - Move-to-special: all bits one cycle later
// - Writes to carry copy bit ignored
// - Selector one picks the status register
`timescale 1ns/10ps
`default_nettype none
`include "cpu_regfile_map.svh"

module cpu_register_file_and_status
    import cpu_regfile_pkg::*;
#(
    parameter int         NUM_SPECIAL   = 18,
    parameter bit         EXC_SUPPORT   = 1'b1,
    parameter logic       PVR_PRESENT   = 1'b0
)
(
    input  wire logic     clk,
    input  wire logic     rst,
    input  wire logic     core_reset_input,
    input  wire logic     debug_reset_input,
    input  wire logic     rd_a_en,
    input  wire logic [4:0]  rd_a_addr,
    output var  logic [31:0] rd_a_data,
    input  wire logic     rd_b_en,
    input  wire logic [4:0]  rd_b_addr,
    output var  logic [31:0] rd_b_data,
    input  wire logic     wr_en,
    input  wire logic [4:0]  wr_addr,
    input  wire logic [31:0] wr_data,
    input  wire logic     irq_take,
    input  wire logic [31:0] irq_ret_addr,
    input  wire logic     brk_take,
    input  wire logic [31:0] brk_ret_addr,
    input  wire logic     exc_take,
    input  wire logic     exc_in_delay,
    input  wire logic [31:0] exc_next_addr,
    input  wire logic [31:0] exc_branch_target,
    input  wire logic     pc_load,
    input  wire logic [31:0] pc_next,
    input  wire logic     mfs_en,
    input  wire logic [15:0] special_selector_read,
    output var  logic [31:0] mfs_data,
    input  wire logic     move_to_special,
    input  wire logic [15:0] special_selector,
    input  wire logic [31:0] mts_data,
    input  wire logic     status_bit_set,
    input  wire logic     status_bit_clear,
    input  wire logic [31:0] status_mask,
    input  wire logic     carry_wr_en,
    input  wire logic     carry_in,
    output var  logic [31:0] pc,
    output var  logic [31:0] machine_status,
    output var  logic [31:0] branch_target_register
);

    // Reset pins come from outside the core clock domain
    logic [1:0]      core_rst_sync_ff;
    logic [1:0]      dbg_rst_sync_ff;
    logic            any_rst;

    // Loaded with the configuration image only; no reset path
    word_type        gpr_mem [0:31] = '{default: `GPR_INIT};
    word_type        pc_ff;
    word_type        btr_ff;
    word_type        rd_a_ff;
    word_type        rd_b_ff;
    word_type        mfs_ff;
    status_word_type status_ff;
    status_word_type pend_val_ff;
    logic            pend_valid_ff;
    logic            pend_carry_ff;

    gpr_src_type     gpr_src;
    gpr_index_type   gpr_wr_idx;
    word_type        gpr_wr_val;
    status_word_type status_base;
    status_word_type nxt_status_upd;
    logic            mts_hit;
    logic            bitop_hit;

    always_ff @(posedge clk)
    begin
        core_rst_sync_ff <= {core_rst_sync_ff[0], core_reset_input};
        dbg_rst_sync_ff  <= {dbg_rst_sync_ff[0], debug_reset_input};
    end

    assign any_rst = rst | core_rst_sync_ff[1] | dbg_rst_sync_ff[1];

    // Hardware link writes win over the port; one write per cycle
    always_comb
    begin
        gpr_src    = SRC_NONE;
        gpr_wr_idx = `GPR_ZERO;
        gpr_wr_val = wr_data;
        if (irq_take)
        begin
            gpr_src    = SRC_IRQ;
            gpr_wr_idx = `GPR_IRQ_LINK;
            gpr_wr_val = irq_ret_addr;
        end
        else if (brk_take)
        begin
            gpr_src    = SRC_BRK;
            gpr_wr_idx = `GPR_BRK_LINK;
            gpr_wr_val = brk_ret_addr;
        end
        else if (exc_take && EXC_SUPPORT && !exc_in_delay)
        begin
            gpr_src    = SRC_EXC;
            gpr_wr_idx = `GPR_EXC_LINK;
            gpr_wr_val = exc_next_addr;
        end
        else if (wr_en)
        begin
            gpr_src    = SRC_PORT;
            gpr_wr_idx = wr_addr;
        end
    end

    // Not gated by any reset input
    always_ff @(posedge clk)
    begin
        if (gpr_src != SRC_NONE && gpr_wr_idx != `GPR_ZERO)
            gpr_mem[gpr_wr_idx] <= gpr_wr_val;
    end

    // Delay-slot faults keep the branch target instead of the link
    always_ff @(posedge clk)
    begin
        if (any_rst)
            btr_ff <= `PC_RESET;
        else if (exc_take && EXC_SUPPORT && exc_in_delay && !irq_take && !brk_take)
            btr_ff <= exc_branch_target;
    end

    // Read ports see the old value on a same-cycle write
    always_ff @(posedge clk)
    begin
        if (rd_a_en)
            rd_a_ff <= (rd_a_addr == `GPR_ZERO) ? `GPR_INIT : gpr_mem[rd_a_addr];
        if (rd_b_en)
            rd_b_ff <= (rd_b_addr == `GPR_ZERO) ? `GPR_INIT : gpr_mem[rd_b_addr];
    end

    always_ff @(posedge clk)
    begin
        if (any_rst)
            pc_ff <= `PC_RESET;
        else if (pc_load)
            pc_ff <= pc_next;
    end

    assign mts_hit   = move_to_special && special_selector == `SEL_STATUS;
    assign bitop_hit = !mts_hit && (status_bit_set || status_bit_clear);

    // Set and clear act on the newest value, pending one included
    always_comb
    begin
        status_base    = pend_valid_ff ? pend_val_ff : status_ff;
        nxt_status_upd = status_base;
        if (mts_hit)
            nxt_status_upd = (mts_data & `STATUS_WR_MASK) | (status_base & ~`STATUS_WR_MASK);
        else if (status_bit_set)
            nxt_status_upd = status_base | (status_mask & `STATUS_WR_MASK);
        else if (status_bit_clear)
            nxt_status_upd = status_base & ~(status_mask & `STATUS_WR_MASK);
    end

    always_ff @(posedge clk)
    begin
        if (any_rst)
        begin
            pend_valid_ff <= 1'b0;
            pend_carry_ff <= 1'b0;
            pend_val_ff   <= `STATUS_RESET;
        end
        else
        begin
            pend_valid_ff <= mts_hit || bitop_hit;
            pend_carry_ff <= mts_hit;
            pend_val_ff   <= nxt_status_upd;
        end
    end

    // Carry has its own path so bit operations reach it a cycle early
    always_ff @(posedge clk)
    begin
        if (any_rst)
        begin
            status_ff <= `STATUS_RESET;
            status_ff[`STATUS_PVR] <= 1'b0;
        end
        else
        begin
            if (pend_valid_ff)
            begin
                status_ff[1:28]  <= pend_val_ff[1:28];
                status_ff[30:31] <= pend_val_ff[30:31];
            end
            if (bitop_hit)
                status_ff[`STATUS_CARRY] <= nxt_status_upd[`STATUS_CARRY];
            else if (pend_valid_ff && pend_carry_ff)
                status_ff[`STATUS_CARRY] <= pend_val_ff[`STATUS_CARRY];
            else if (carry_wr_en)
                status_ff[`STATUS_CARRY] <= carry_in;
            status_ff[`STATUS_COPY] <= 1'b0;
            status_ff[`STATUS_PVR]  <= PVR_PRESENT;
        end
    end

    // Unimplemented special registers read as zero
    always_ff @(posedge clk)
    begin
        if (any_rst)
            mfs_ff <= `PC_RESET;
        else if (mfs_en)
        begin
            if (special_selector_read == `SEL_PC)
                mfs_ff <= pc_ff;
            else if (special_selector_read == `SEL_STATUS)
            begin
                mfs_ff <= status_ff;
                mfs_ff[31 - `STATUS_COPY] <= status_ff[`STATUS_CARRY];
            end
            else
                mfs_ff <= `GPR_INIT;
        end
    end

    assign rd_a_data              = rd_a_ff;
    assign rd_b_data              = rd_b_ff;
    assign mfs_data               = mfs_ff;
    assign pc                     = pc_ff;
    assign machine_status         = status_ff;
    assign branch_target_register = btr_ff;

    a_zero_reads: assert property (@(posedge clk)
        rd_a_en && rd_a_addr == `GPR_ZERO |=> rd_a_data == 32'h0000_0000)
        else $error("zero register read nonzero");

    a_irq_link: assert property (@(posedge clk)
        irq_take |=> gpr_mem[`GPR_IRQ_LINK] == $past(irq_ret_addr))
        else $error("interrupt link not loaded");

    a_brk_link: assert property (@(posedge clk)
        brk_take && !irq_take |=> gpr_mem[`GPR_BRK_LINK] == $past(brk_ret_addr))
        else $error("break link not loaded");

    a_exc_delay_btr: assert property (@(posedge clk) disable iff (any_rst)
        exc_take && exc_in_delay && !irq_take && !brk_take |=>
        branch_target_register == $past(exc_branch_target) &&
        $stable(gpr_mem[`GPR_EXC_LINK]))
        else $error("delay slot fault handled wrong");

    a_gpr_keep_rst: assert property (@(posedge clk)
        any_rst && !wr_en && !irq_take && !brk_take && !exc_take |=>
        gpr_mem[1] == $past(gpr_mem[1]))
        else $error("reset changed general register");

    a_pc_read_own: assert property (@(posedge clk) disable iff (any_rst)
        mfs_en && special_selector_read == `SEL_PC |=> mfs_data == $past(pc_ff))
        else $error("pc read wrong");

    a_pc_no_write: assert property (@(posedge clk) disable iff (any_rst)
        move_to_special && special_selector == `SEL_PC && !pc_load |=> pc == $past(pc))
        else $error("pc written by move");

    a_pc_reset: assert property (@(posedge clk) rst |=> pc == 32'h0000_0000)
        else $error("pc not reset");

    a_carry_copy: assert property (@(posedge clk) disable iff (any_rst)
        mfs_en && special_selector_read == `SEL_STATUS |=>
        mfs_data[31] == mfs_data[2] && mfs_data[2] == $past(status_ff[`STATUS_CARRY]))
        else $error("carry copy wrong");

    a_mts_late: assert property (@(posedge clk) disable iff (any_rst)
        mts_hit && !carry_wr_en ##1 !(mts_hit || bitop_hit) |=>
        status_ff[`STATUS_CARRY] == $past(mts_data[2], 2) &&
        status_ff[23] == $past(mts_data[8], 2))
        else $error("move update timing wrong");

    a_set_carry_now: assert property (@(posedge clk) disable iff (any_rst)
        status_bit_set && !mts_hit && status_mask[2] |=> status_ff[`STATUS_CARRY]
        ##1 status_ff[`STATUS_CARRY])
        else $error("set carry late");

    a_copy_dropped: assert property (@(posedge clk) disable iff (any_rst)
        mts_hit |-> ##2 status_ff[`STATUS_COPY] == 1'b0)
        else $error("copy bit stored");

    c_irq_taken:   cover property (@(posedge clk) irq_take);
    c_mts_status:  cover property (@(posedge clk) mts_hit ##2 mfs_en);
    c_bit_set:     cover property (@(posedge clk) status_bit_set && status_mask[2]);
    c_delay_fault: cover property (@(posedge clk) exc_take && exc_in_delay);

endmodule
`default_nettype wire

// ===== cpu_regfile_map.svh
`ifndef CPU_REGFILE_MAP_SVH
`define CPU_REGFILE_MAP_SVH

// Special register selectors
`define SEL_PC          16'h0000
`define SEL_STATUS      16'h0001

// General register indices with fixed duties
`define GPR_ZERO        5'h00
`define GPR_IRQ_LINK    5'h0e
`define GPR_USER_LINK   5'h0f
`define GPR_BRK_LINK    5'h10
`define GPR_EXC_LINK    5'h11

// Status bit positions, bit 0 is the most significant
`define STATUS_COPY     0
`define STATUS_PVR      21
`define STATUS_CARRY    29

// Reset and load values
`define GPR_INIT        32'h0000_0000
`define PC_RESET        32'h0000_0000
`define STATUS_RESET    32'h0000_0000
// Writable status bits: all but the carry copy and the version flag
`define STATUS_WR_MASK  32'h7fff_fbff

`endif

// ===== cpu_regfile_pkg.sv
package cpu_regfile_pkg;

    typedef logic [31:0] word_type;
    typedef logic [0:31] status_word_type;
    typedef logic [4:0]  gpr_index_type;

    // Source of the cycle's general register write, one-hot
    typedef enum logic [4:0]
    {
        SRC_NONE = 5'b00001,
        SRC_IRQ  = 5'b00010,
        SRC_BRK  = 5'b00100,
        SRC_EXC  = 5'b01000,
        SRC_PORT = 5'b10000
    } gpr_src_type;

endpackage

// ===== tb_cpu_register_file_and_status.sv
`timescale 1ns/10ps
`default_nettype none
`include "cpu_regfile_map.svh"

module tb_cpu_register_file_and_status
    import cpu_regfile_pkg::*;
;
    logic          clk;
    logic          rst;
    logic          core_reset_input;
    logic          debug_reset_input;
    logic          rd_a_en;
    logic          rd_b_en;
    logic          wr_en;
    logic          irq_take;
    logic          brk_take;
    logic          exc_take;
    logic          exc_in_delay;
    logic          pc_load;
    logic          mfs_en;
    logic          move_to_special;
    logic          status_bit_set;
    logic          status_bit_clear;
    logic          carry_wr_en;
    logic          carry_in;
    gpr_index_type rd_addr;
    gpr_index_type wr_addr;
    logic [15:0]   special_selector_read;
    logic [15:0]   special_selector;
    word_type      value;
    word_type      status_mask;
    word_type      rd_a_data;
    word_type      rd_b_data;
    word_type      mfs_data;
    word_type      pc;
    word_type      machine_status;
    word_type      branch_target_register;
    int            fail_count;
    int            checks;
    int            cycles;

    // One data bus feeds every data, return-address and target input; each test sets it before its strobe
    cpu_register_file_and_status dut (
        .clk(clk), .rst(rst), .core_reset_input(core_reset_input),
        .debug_reset_input(debug_reset_input), .rd_a_en(rd_a_en), .rd_a_addr(rd_addr),
        .rd_a_data(rd_a_data), .rd_b_en(rd_b_en), .rd_b_addr(rd_addr), .rd_b_data(rd_b_data),
        .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(value), .irq_take(irq_take),
        .irq_ret_addr(value), .brk_take(brk_take), .brk_ret_addr(value), .exc_take(exc_take),
        .exc_in_delay(exc_in_delay), .exc_next_addr(value), .exc_branch_target(value),
        .pc_load(pc_load), .pc_next(value), .mfs_en(mfs_en),
        .special_selector_read(special_selector_read), .mfs_data(mfs_data),
        .move_to_special(move_to_special), .special_selector(special_selector),
        .mts_data(value), .status_bit_set(status_bit_set), .status_bit_clear(status_bit_clear),
        .status_mask(status_mask), .carry_wr_en(carry_wr_en), .carry_in(carry_in), .pc(pc),
        .machine_status(machine_status), .branch_target_register(branch_target_register)
    );

    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic step(input int n);
        repeat (n)
        begin
            @(posedge clk);
            #1;
        end
    endtask

    task automatic chk(input word_type got, input word_type exp, input string what);
        checks++;
        if (got !== exp)
            $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
        if (got !== exp)
            fail_count++;
    endtask

    task automatic rd(input gpr_index_type idx, input word_type exp);
        rd_addr = idx;
        rd_a_en = 1'b1;
        rd_b_en = 1'b1;
        step(1);
        rd_a_en = 1'b0;
        rd_b_en = 1'b0;
        step(1);
        chk(rd_a_data, exp, "read port a");
        chk(rd_b_data, exp, "read port b");
    endtask

    task automatic wr(input gpr_index_type idx, input word_type data);
        wr_addr = idx;
        value = data;
        wr_en = 1'b1;
        step(1);
        wr_en = 1'b0;
    endtask

    task automatic load_pc(input word_type addr);
        value = addr;
        pc_load = 1'b1;
        step(1);
        pc_load = 1'b0;
    endtask

    task automatic mfs(input logic [15:0] sel, input word_type mask, input word_type exp);
        special_selector_read = sel;
        mfs_en = 1'b1;
        step(1);
        mfs_en = 1'b0;
        step(1);
        chk(mfs_data & mask, exp, "special read");
    endtask

    // Carry lands one edge ahead of the other status bits
    task automatic flip(input logic clr, input word_type e1, input word_type e2);
        status_mask = 32'h0000_0006;
        status_bit_set = ~clr;
        status_bit_clear = clr;
        step(1);
        status_bit_set = 1'b0;
        status_bit_clear = 1'b0;
        chk(machine_status & status_mask, e1, "carry at once");
        step(1);
        chk(machine_status & status_mask, e2, "other bits later");
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            fail_count++;
            summarize();
        end
    end

    initial
    begin
        {rst, core_reset_input, debug_reset_input, rd_a_en, rd_b_en, wr_en} = 6'h20;
        {irq_take, brk_take, exc_take, exc_in_delay, pc_load, mfs_en} = 6'h00;
        {move_to_special, status_bit_set, status_bit_clear, carry_wr_en, carry_in} = 5'h00;
        {rd_addr, wr_addr, special_selector_read, special_selector} = 42'h0;
        {value, status_mask, fail_count, checks, cycles} = '0;
        step(8);
        rst = 1'b0;
        chk(pc, `PC_RESET, "pc after reset");
        rd(5'h07, `GPR_INIT);
        wr(`GPR_ZERO, 32'hffff_ffff);
        rd(`GPR_ZERO, 32'h0000_0000);
        wr(5'h05, 32'hdead_beef);
        rd(5'h05, 32'hdead_beef);
        wr(`GPR_USER_LINK, 32'h0000_5678);
        rd(`GPR_USER_LINK, 32'h0000_5678);
        $display("test general registers done");
        value = 32'h0000_1234;
        irq_take = 1'b1;
        step(1);
        irq_take = 1'b0;
        rd(`GPR_IRQ_LINK, 32'h0000_1234);
        value = 32'h0000_2345;
        brk_take = 1'b1;
        step(1);
        brk_take = 1'b0;
        rd(`GPR_BRK_LINK, 32'h0000_2345);
        value = 32'h0000_3456;
        exc_take = 1'b1;
        step(1);
        value = 32'h0000_4567;
        exc_in_delay = 1'b1;
        step(1);
        {exc_take, exc_in_delay} = 2'b00;
        step(1);
        chk(branch_target_register, 32'h0000_4567, "delay slot target");
        rd(`GPR_EXC_LINK, 32'h0000_3456);
        $display("test return links done");
        load_pc(32'h0000_0100);
        mfs(`SEL_PC, 32'hffff_ffff, 32'h0000_0100);
        mfs(16'h0002, 32'hffff_ffff, 32'h0000_0000);
        value = 32'h5555_0000;
        special_selector = `SEL_PC;
        move_to_special = 1'b1;
        step(1);
        move_to_special = 1'b0;
        step(1);
        chk(pc, 32'h0000_0100, "pc not writable");
        $display("test program counter done");
        flip(1'b0, 32'h0000_0004, 32'h0000_0006);
        flip(1'b1, 32'h0000_0002, 32'h0000_0000);
        value = 32'hffff_ffff;
        special_selector = `SEL_STATUS;
        move_to_special = 1'b1;
        step(1);
        move_to_special = 1'b0;
        chk(machine_status, `STATUS_RESET, "move not yet seen");
        step(1);
        chk(machine_status & `STATUS_WR_MASK, 32'h7fff_fbff, "move seen");
        chk(machine_status & 32'h8000_0400, 32'h0000_0000, "copy and version kept");
        mfs(`SEL_STATUS, 32'hffff_ffff, 32'hffff_fbff);
        carry_in = 1'b0;
        carry_wr_en = 1'b1;
        step(1);
        carry_wr_en = 1'b0;
        mfs(`SEL_STATUS, 32'h8000_0004, 32'h0000_0000);
        $display("test status done");
        rst = 1'b1;
        step(2);
        rst = 1'b0;
        chk(pc, `PC_RESET, "pc after system reset");
        load_pc(32'h0000_0200);
        core_reset_input = 1'b1;
        step(4);
        core_reset_input = 1'b0;
        chk(pc, `PC_RESET, "pc after core reset");
        // Synchroniser keeps reset up two more edges
        step(2);
        load_pc(32'h0000_0300);
        debug_reset_input = 1'b1;
        step(4);
        debug_reset_input = 1'b0;
        chk(pc, `PC_RESET, "pc after debug reset");
        step(2);
        rd(5'h05, 32'hdead_beef);
        $display("test resets done");
        summarize();
    end
endmodule
`default_nettype wire
